//--- core/rqc_consts.svh
// constant values for the requantizer configuration registers
`ifndef RQC_CONSTS_SVH
`define RQC_CONSTS_SVH

// register addresses on the serial port
`define RQC_CTRL_ADDR 13'h003c
`define RQC_TUNE_ADDR 13'h003e

// reset values
`define RQC_CTRL_RESET 8'h00
`define RQC_TUNE_RESET 8'h1c

// control register fields
`define RQC_EN_BIT 0
`define RQC_MODE_LSB 1
`define RQC_MODE_MSB 3

// bandwidth mode codes
`define RQC_MODE_22 3'h0
`define RQC_MODE_33 3'h1

// highest tuning word per mode: 57 and 34 values from zero
`define RQC_TW_MAX22 6'h38
`define RQC_TW_MAX33 6'h21

// last bit count of the serial instruction and of a data byte
`define RQC_INSTR_LAST 4'hf
`define RQC_BYTE_LAST 4'h7

`endif

//--- core/rqc_pkg.sv
// types for the requantizer configuration registers
package rqc_pkg;

    typedef enum logic {rqc_instr, rqc_data} rqc_serial_e;

    typedef logic [7:0] rqc_byte_t;

    typedef logic [12:0] rqc_addr_t;

endpackage

//--- core/rqc_pin_sync.sv
// three-stage synchroniser for one serial port pin
`timescale 1ns/100ps

module rqc_pin_sync
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // pin and filtered level
    input wire logic pin,
    output logic level
);

    logic meta;
    logic stage2;
    logic stage3;
    logic next_level;

    // a change counts only once the second and third stages agree
    always_comb
    begin
        next_level = level;
        if (stage2 == stage3)
        begin
            next_level = stage3;
        end
    end

    // register the chain
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            meta <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            meta <= pin;
            stage2 <= meta;
            stage3 <= stage2;
            level <= next_level;
        end
    end

endmodule

//--- core/rqc_config_regs.sv
// requantizer configuration registers behind the three-wire serial port
`timescale 1ns/100ps
`include "rqc_consts.svh"

// Operation
// - a bandwidth mode field of 000 runs the requantizer in its 22 percent bandwidth mode.
// - a bandwidth mode field of 001 runs the requantizer in its 33 percent bandwidth mode.
// - control bit 0 high enables requantizer processing and low bypasses it.
// - the six-bit tuning word in the tuning register sets the band edges.
// - in 22 percent mode the tuning word takes one of 57 values, and the host writes only those.
// - in 33 percent mode the tuning word takes one of 34 values, and the host writes only those.
// - each tuning word step moves the band by half a percent of the sample rate.
module rqc_config_regs
    import rqc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // serial port pins
    input wire logic sclk,
    input wire logic port_select_lown,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    // settings to the requantizer datapath
    output logic requantizer_enable,
    output logic bandwidth_33,
    output logic [5:0] band_tuning
);

    logic [2:0] pins;
    logic [2:0] pins_s;
    logic sclk_s;
    logic select_lown_s;
    logic sdio_s;

    // pin synchronisers for clock, select and data
    assign pins = {sclk, port_select_lown, sdio_in};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            rqc_pin_sync u_sync
            (
                .clock(clock),
                .resetn(resetn),
                .pin(pins[gi]),
                .level(pins_s[gi])
            );
        end
    endgenerate

    assign sclk_s = pins_s[2];
    assign select_lown_s = pins_s[1];
    assign sdio_s = pins_s[0];

    logic ctrl_enable;
    logic [2:0] ctrl_mode;
    logic [5:0] tune;
    rqc_serial_e state;
    logic [3:0] bit_cnt;
    logic [15:0] shift_in;
    logic rw;
    rqc_addr_t addr;
    rqc_byte_t rd_shift;
    logic sclk_prev;
    logic wr_strobe;
    rqc_byte_t wr_data;

    logic next_ctrl_enable;
    logic [2:0] next_ctrl_mode;
    logic [5:0] next_tune;
    rqc_serial_e next_state;
    logic [3:0] next_bit_cnt;
    logic [15:0] next_shift_in;
    logic next_rw;
    rqc_addr_t next_addr;
    rqc_byte_t next_rd_shift;
    logic next_sdio_out;
    logic next_sdio_oe;
    logic next_wr_strobe;
    rqc_byte_t next_wr_data;
    logic next_requantizer_enable;
    logic next_bandwidth_33;
    logic [5:0] next_band_tuning;
    logic rise;
    logic fall;
    logic [5:0] tw_max;

    // whole-register reset values, named so that fields can be sliced out of them
    localparam rqc_byte_t ctrl_reset_value = `RQC_CTRL_RESET;
    localparam rqc_byte_t tune_reset_value = `RQC_TUNE_RESET;

    // read-back value of a register, zero in reserved bits and unmapped addresses
    function automatic rqc_byte_t reg_read(input rqc_addr_t a, input logic en,
                                          input logic [2:0] mode, input logic [5:0] tw);
        rqc_byte_t v;
        v = 8'h00;
        if (a == `RQC_CTRL_ADDR)
        begin
            v = {4'h0, mode, en};
        end
        else if (a == `RQC_TUNE_ADDR)
        begin
            v = {2'h0, tw};
        end
        return v;
    endfunction

    assign rise = sclk_s && !sclk_prev;
    assign fall = !sclk_s && sclk_prev;

    // serial framing: 16-bit instruction then data bytes, address incrementing
    always_comb
    begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_rw = rw;
        next_addr = addr;
        next_rd_shift = rd_shift;
        next_sdio_out = sdio_out;
        next_sdio_oe = sdio_oe;
        next_wr_strobe = 1'b0;
        next_wr_data = wr_data;
        if (select_lown_s)
        begin
            next_state = rqc_instr;
            next_bit_cnt = 4'h0;
            next_sdio_oe = 1'b0;
            next_sdio_out = 1'b0;
        end
        else if (rise)
        begin
            next_shift_in = {shift_in[14:0], sdio_s};
            next_bit_cnt = bit_cnt + 4'h1;
            case (state)
                rqc_instr:
                begin
                    if (bit_cnt == `RQC_INSTR_LAST)
                    begin
                        next_rw = next_shift_in[15];
                        next_addr = next_shift_in[12:0];
                        next_state = rqc_data;
                        next_bit_cnt = 4'h0;
                        next_rd_shift = reg_read(next_shift_in[12:0], ctrl_enable,
                                                 ctrl_mode, tune);
                        next_sdio_oe = next_shift_in[15];
                    end
                end
                rqc_data:
                begin
                    if (bit_cnt == `RQC_BYTE_LAST)
                    begin
                        next_bit_cnt = 4'h0;
                        next_wr_strobe = !rw;
                        next_wr_data = next_shift_in[7:0];
                        next_addr = addr + 13'h0001;
                        next_rd_shift = reg_read(addr + 13'h0001, ctrl_enable,
                                                 ctrl_mode, tune);
                    end
                end
                default:
                begin
                    next_state = rqc_instr;
                end
            endcase
        end
        else if (fall && state == rqc_data && rw)
        begin
            next_sdio_out = rd_shift[7];
            next_rd_shift = {rd_shift[6:0], 1'b0};
        end
    end

    // register writes; wr_strobe follows the byte so addr has already moved on
    always_comb
    begin
        next_ctrl_enable = ctrl_enable;
        next_ctrl_mode = ctrl_mode;
        next_tune = tune;
        if (wr_strobe && (addr - 13'h0001) == `RQC_CTRL_ADDR)
        begin
            next_ctrl_enable = wr_data[`RQC_EN_BIT];
            if (wr_data[`RQC_MODE_MSB:`RQC_MODE_LSB] <= `RQC_MODE_33)
            begin
                next_ctrl_mode = wr_data[`RQC_MODE_MSB:`RQC_MODE_LSB];
            end
        end
        else if (wr_strobe && (addr - 13'h0001) == `RQC_TUNE_ADDR)
        begin
            next_tune = wr_data[5:0];
        end
    end

    // settings handed to the datapath, tuning held inside the mode's valid set
    always_comb
    begin
        next_requantizer_enable = ctrl_enable;
        next_bandwidth_33 = (ctrl_mode == `RQC_MODE_33);
        tw_max = next_bandwidth_33 ? `RQC_TW_MAX33 : `RQC_TW_MAX22;
        next_band_tuning = (tune > tw_max) ? tw_max : tune;
    end

    // state registers
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_enable <= ctrl_reset_value[`RQC_EN_BIT];
            ctrl_mode <= ctrl_reset_value[`RQC_MODE_MSB:`RQC_MODE_LSB];
            tune <= tune_reset_value[5:0];
            state <= rqc_instr;
            bit_cnt <= 4'h0;
            shift_in <= 16'h0000;
            rw <= 1'b0;
            addr <= 13'h0000;
            rd_shift <= 8'h00;
            sclk_prev <= 1'b0;
            sdio_out <= 1'b0;
            sdio_oe <= 1'b0;
            wr_strobe <= 1'b0;
            wr_data <= 8'h00;
            requantizer_enable <= 1'b0;
            bandwidth_33 <= 1'b0;
            band_tuning <= tune_reset_value[5:0];
        end
        else
        begin
            ctrl_enable <= next_ctrl_enable;
            ctrl_mode <= next_ctrl_mode;
            tune <= next_tune;
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            rw <= next_rw;
            addr <= next_addr;
            rd_shift <= next_rd_shift;
            sclk_prev <= sclk_s;
            sdio_out <= next_sdio_out;
            sdio_oe <= next_sdio_oe;
            wr_strobe <= next_wr_strobe;
            wr_data <= next_wr_data;
            requantizer_enable <= next_requantizer_enable;
            bandwidth_33 <= next_bandwidth_33;
            band_tuning <= next_band_tuning;
        end
    end

    // checks on the settings
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    sequence tune_write_s;
        wr_strobe && (addr - 13'h0001) == `RQC_TUNE_ADDR;
    endsequence

    sequence tune_step_s;
        (tune == $past(tune) + 6'h1) && $stable(ctrl_mode) && (tune <= `RQC_TW_MAX33);
    endsequence

    mode_22_a: assert property (ctrl_mode == `RQC_MODE_22 |=> !bandwidth_33)
        else $error("22 percent mode not selected");
    mode_33_a: assert property (ctrl_mode == `RQC_MODE_33 |=> bandwidth_33)
        else $error("33 percent mode not selected");
    enable_follow_a: assert property (##1 requantizer_enable == $past(ctrl_enable))
        else $error("requantizer enable does not follow control bit");
    tune_write_a: assert property (tune_write_s |=> tune == $past(wr_data[5:0]))
        else $error("tuning word not stored");
    limit_22_a: assert property (!bandwidth_33 |-> band_tuning <= `RQC_TW_MAX22)
        else $error("tuning word outside 22 percent set");
    limit_33_a: assert property (bandwidth_33 |-> band_tuning <= `RQC_TW_MAX33)
        else $error("tuning word outside 33 percent set");
    tune_step_a: assert property (tune_step_s |=>
        band_tuning == $past(band_tuning) + 6'h1)
        else $error("tuning step does not move band by one");
    mode_reserved_a: assert property (ctrl_mode <= `RQC_MODE_33)
        else $error("reserved mode code stored");

endmodule

//--- testbench/rqc_host_model.sv
// serial port host model that drives the configuration port
`timescale 1ns/100ps

module rqc_host_model
(
    // clock
    input wire logic clock,
    // serial port pins and shared data wire level
    output logic sclk,
    output logic port_select_lown,
    output logic sdio_host,
    input wire logic sdio
);
    // port idle: clock still and low, select high
    initial
    begin
        sclk = 1'b0;
        port_select_lown = 1'b1;
        sdio_host = 1'b1;
    end

    // wait n clocks, then step just off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // one frame: instruction then nb bytes msb first; in write frames data words are sent as given, unchecked
    task automatic frame(input logic [15:0] ins, input int nb, input logic [23:0] wd,
        output logic [23:0] rd);
        logic [39:0] v;
        v = {ins, wd};
        rd = 24'h000000;
        port_select_lown = 1'b0;
        tick(10);
        for (int i = 39; i > 23 - 8 * nb; i--)
        begin
            // released wire toggles so stale data never looks valid
            if (ins[15] && i < 24)
                sdio_host = ~sdio_host;
            else
                sdio_host = v[i];
            tick(10);
            rd = {rd[22:0], sdio};
            sclk = 1'b1;
            tick(10);
            sclk = 1'b0;
        end
        tick(10);
        port_select_lown = 1'b1;
        sdio_host = ~sdio_host;
        tick(10);
    endtask
endmodule

//--- testbench/test_rqc_config_regs.sv
// self-checking bench for the requantizer configuration registers
`timescale 1ns/100ps

module test_rqc_config_regs;
    logic clock, resetn, sclk, port_select_lown, sdio_host, sdio_out, sdio_oe, sdio;
    logic requantizer_enable, bandwidth_33;
    logic [5:0] band_tuning;
    logic [23:0] rd;
    int n_mismatch = 0;
    int n_checks = 0;

    // shared data wire: device wins while it drives
    assign sdio = sdio_oe ? sdio_out : sdio_host;

    // 125 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    rqc_config_regs rqc_config_regs_i (.clock(clock), .resetn(resetn), .sclk(sclk),
        .port_select_lown(port_select_lown), .sdio_in(sdio), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .requantizer_enable(requantizer_enable),
        .bandwidth_33(bandwidth_33), .band_tuning(band_tuning));

    rqc_host_model rqc_host_model_i (.clock(clock), .sclk(sclk),
        .port_select_lown(port_select_lown), .sdio_host(sdio_host), .sdio(sdio));

    // compare and count
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // counts, verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // single byte write and read
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        rqc_host_model_i.frame({3'h0, a}, 1, {d, 16'h0000}, rd);
    endtask

    task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
        rqc_host_model_i.frame({3'h4, a}, 1, 24'h000000, rd);
        check({16'h0000, rd[7:0]}, {16'h0000, exp});
    endtask

    // datapath settings as one value: enable, mode, tuning
    task automatic outs(input logic e, input logic b, input logic [5:0] t);
        check({16'h0000, requantizer_enable, bandwidth_33, band_tuning}, {16'h0000, e, b, t});
    endtask

    // reset values of outputs and registers
    task automatic test_reset();
        outs(1'b0, 1'b0, 6'h1c);
        rd_chk(13'h003c, 8'h00);
        rd_chk(13'h003e, 8'h1c);
        $display("test reset done");
    endtask

    // both modes, enable and bypass
    task automatic test_modes();
        wr(13'h003c, 8'h01);
        outs(1'b1, 1'b0, 6'h1c);
        wr(13'h003c, 8'h03);
        outs(1'b1, 1'b1, 6'h1c);
        wr(13'h003c, 8'h02);
        outs(1'b0, 1'b1, 6'h1c);
        rd_chk(13'h003c, 8'h02);
        $display("test modes done");
    endtask

    // reserved mode code and reserved bits
    task automatic test_reserved();
        wr(13'h003c, 8'hf5);
        rd_chk(13'h003c, 8'h03);
        outs(1'b1, 1'b1, 6'h1c);
        $display("test reserved done");
    endtask

    // tuning word in both modes, top values
    task automatic test_tuning();
        wr(13'h003e, 8'he1);
        rd_chk(13'h003e, 8'h21);
        outs(1'b1, 1'b1, 6'h21);
        wr(13'h003e, 8'h20);
        outs(1'b1, 1'b1, 6'h20);
        wr(13'h003e, 8'h21);
        outs(1'b1, 1'b1, 6'h21);
        wr(13'h003c, 8'h01);
        wr(13'h003e, 8'h38);
        outs(1'b1, 1'b0, 6'h38);
        $display("test tuning done");
    endtask

    // streaming across the unmapped address between the registers
    task automatic test_stream();
        rqc_host_model_i.frame(16'h003c, 3, 24'h02aa05, rd);
        outs(1'b0, 1'b1, 6'h05);
        rd_chk(13'h003d, 8'h00);
        rqc_host_model_i.frame(16'h803c, 3, 24'h000000, rd);
        check(rd, 24'h020005);
        $display("test stream done");
    endtask

    // hang guard
    initial
    begin
        repeat (40000) @(posedge clock);
        $display("timeout");
        n_mismatch++;
        summarize();
    end

    // main sequence
    initial
    begin
        resetn = 1'b0;
        rqc_host_model_i.tick(3);
        resetn = 1'b1;
        rqc_host_model_i.tick(10);
        test_reset();
        test_modes();
        test_reserved();
        test_tuning();
        test_stream();
        summarize();
    end
endmodule
